// >>> rtl/frm_cfg.svh
// Constants for the fault reaction manager: source indices, fault numbers, permissions
`ifndef FRM_CFG_SVH
`define FRM_CFG_SVH

// ********************************************************************
// Fault source indices
// ********************************************************************
`define FRM_NUM_SRC        11
`define FRM_SRC_SYSTEM     0
`define FRM_SRC_PARAM      1
`define FRM_SRC_PROGRAM    2
`define FRM_SRC_OPTCOMM    3
`define FRM_SRC_POLARITY   4
`define FRM_SRC_ANA_ENC    5
`define FRM_SRC_SETP_ENC   6
`define FRM_SRC_ANGLE      7
`define FRM_SRC_OVERLOAD   8
`define FRM_SRC_OVERTEMP   9
`define FRM_SRC_OVERVOLT   10

// ********************************************************************
// Fault numbers shown in the indication codes, index 10 down to 0
// ********************************************************************
`define FRM_FAULT_CODES {8'h16, 8'h32, 8'h0f, 8'ha3, 8'h55, 8'h51, 8'h50, 8'h3d, \
                         8'h49, 8'h48, 8'h47}
`define FRM_CODE_NONE   8'h00

// ********************************************************************
// Permitted reactions per source, bit n allows reaction code n
// ********************************************************************
`define FRM_ALLOW_SHUTDOWN_OUT_ONLY  5'h01
`define FRM_ALLOW_SHUTDOWN_OUT_WARN  5'h03
`define FRM_ALLOW_SHUTDOWN_OUT_OFF   5'h11
`define FRM_ALLOW_TW_OFF     5'h13
`define FRM_ALLOW_TABLE {`FRM_ALLOW_SHUTDOWN_OUT_WARN, `FRM_ALLOW_SHUTDOWN_OUT_WARN, \
                         `FRM_ALLOW_SHUTDOWN_OUT_WARN, `FRM_ALLOW_SHUTDOWN_OUT_OFF, `FRM_ALLOW_TW_OFF, \
                         `FRM_ALLOW_TW_OFF, `FRM_ALLOW_TW_OFF, `FRM_ALLOW_TW_OFF, \
                         `FRM_ALLOW_SHUTDOWN_OUT_ONLY, `FRM_ALLOW_SHUTDOWN_OUT_ONLY, `FRM_ALLOW_SHUTDOWN_OUT_ONLY}

// Sources whose shutdown_out cannot be acknowledged while their fault stands
`define FRM_NON_ACK_MASK 11'h700

// Reset value of every reaction selector: shutdown shutdown_out
`define FRM_REACT_RESET  3'h0

`define FRM_HIST_DEPTH   8
`endif

// >>> rtl/frm_pkg.sv
// Types for the fault reaction manager
package frm_pkg;
  typedef enum logic [2:0]
  {
    FRM_R_SHUTDOWN_OUT     = 3'h0,
    FRM_R_WARN     = 3'h1,
    FRM_R_MSG_IMP  = 3'h2,
    FRM_R_MSG_FREE = 3'h3,
    FRM_R_OFF      = 3'h4
  } frm_reaction_t;

  typedef enum logic [2:0]
  {
    FRM_D_NONE     = 3'h0,
    FRM_D_SHUTDOWN_OUT     = 3'h1,
    FRM_D_WARN     = 3'h2,
    FRM_D_MSG_IMP  = 3'h3,
    FRM_D_MSG_FREE = 3'h4
  } frm_display_t;
endpackage

// >>> rtl/frm_fault_reaction_manager.sv
// Fault reaction manager: per-source reactions, latches, indications and history
`timescale 1ns/1ps
`include "frm_cfg.svh"

// Behaviour
// RULE_01: Each source gets one selectable reaction.
// RULE_02: Shutdown_out inhibits armature and field, clears ready.
// RULE_03: Shutdown_out shown and logged in retained history.
// RULE_04: Shutdown_out latched; reset only after fault gone.
// RULE_05: Warning sets output, indication, retained history.
// RULE_06: Warning latched; reset only after fault gone.
// RULE_07: Message with inhibit blocks armature pulses only.
// RULE_08: Messages shown, logged in mains-cleared history.
// RULE_09: Message without inhibit only sets message output.
// RULE_10: System, parameter, program faults always shutdown_out.
// RULE_11: Option comm fault: shutdown_out, warning or off.
// RULE_12: Polarity fault: shutdown_out, warning or off.
// RULE_13: Encoder faults: shutdown_out, warning or off.
// RULE_14: Angle overflow: shutdown_out or off only.
// RULE_15: Non-acknowledgeable trips reject reset while active.
// RULE_16: Operator avoids warning for protective faults.
// RULE_17: Reaction codes 0 to 4 as listed.
// RULE_18: Active warning also sets pulse inhibit.
// RULE_19: Reaction change keeps shutdown_out latched, display follows.
// RULE_20: Display priority shutdown_out, warning, messages.
// RULE_21: Inputs sampled each cycle, outputs next cycle.
module frm_fault_reaction_manager
#(
  parameter int HIST_DEPTH = `FRM_HIST_DEPTH
)
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [10:0]           fault_i,
  input  wire logic                  cfg_we_i,
  input  wire logic [3:0]            cfg_src_i,
  input  wire frm_pkg::frm_reaction_t reaction_select_i,
  input  wire logic                  fault_reset_i,
  input  wire logic                  mains_off_i,
  input  wire logic                  hist_sel_i,
  input  wire logic [$clog2(HIST_DEPTH)-1:0] hist_idx_i,
  output logic                       cfg_refused_o,
  output logic                       reset_refused_o,
  output logic                       armature_inhibit_o,
  output logic                       field_inhibit_o,
  output logic                       shutdown_out_o,
  output logic                       pulse_inhibit_out_o,
  output logic                       ready_o,
  output logic                       warning_out_o,
  output logic                       message_out_o,
  output logic [7:0]                 shutdown_indication_o,
  output logic [7:0]                 warning_indication_o,
  output logic [7:0]                 message_indication_o,
  output frm_pkg::frm_display_t      display_class_o,
  output logic [7:0]                 display_code_o,
  output logic [7:0]                 hist_code_o
);
  import frm_pkg::*;

  localparam int NS = `FRM_NUM_SRC;
  localparam int PW = $clog2(HIST_DEPTH);
  localparam logic [NS*8-1:0] CODES = `FRM_FAULT_CODES;
  localparam logic [NS*5-1:0] ALLOW = `FRM_ALLOW_TABLE;
  localparam logic [NS-1:0] NON_ACK = `FRM_NON_ACK_MASK;

  // Pointers wrap by overflow, so the depth must be a power of two
  if (HIST_DEPTH < 2 || (HIST_DEPTH & (HIST_DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("HIST_DEPTH must be a power of two of at least 2");
  end

  // ******************************************************************
  // Reaction selectors
  // ******************************************************************
  frm_reaction_t react [NS];
  logic          cfg_ok;

  assign cfg_ok = cfg_src_i < 4'(NS) && reaction_select_i <= FRM_R_OFF &&
    ALLOW[5*cfg_src_i + 32'(reaction_select_i)]; // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NS; i++)
        react[i] <= frm_reaction_t'(`FRM_REACT_RESET);
      cfg_refused_o <= 1'b0;
    end
    else
    begin
      cfg_refused_o <= cfg_we_i && !cfg_ok;
      // Latches are not touched here, so a shutdown_out survives a reaction change
      if (cfg_we_i && cfg_ok)
        react[cfg_src_i] <= reaction_select_i; // RULE_01 RULE_17 RULE_19
    end
  end

  // ******************************************************************
  // Per-source latches
  // ******************************************************************
  logic [NS-1:0] shutdown_out_l;
  logic [NS-1:0] warn_l;
  logic [NS-1:0] msg_imp;
  logic [NS-1:0] msg_free;
  logic [NS-1:0] hit_shutdown_out;
  logic [NS-1:0] hit_warn;
  logic [NS-1:0] hit_imp;
  logic [NS-1:0] hit_free;
  logic          ack_block;

  always_comb
  begin
    for (int i = 0; i < NS; i++)
    begin
      hit_shutdown_out[i] = fault_i[i] && react[i] == FRM_R_SHUTDOWN_OUT;
      hit_warn[i] = fault_i[i] && react[i] == FRM_R_WARN;
      hit_imp[i]  = fault_i[i] && react[i] == FRM_R_MSG_IMP;
      hit_free[i] = fault_i[i] && react[i] == FRM_R_MSG_FREE;
    end
    // Protective trips refuse any acknowledge until their fault is gone
    ack_block = |(shutdown_out_l & fault_i & NON_ACK); // RULE_15
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      shutdown_out_l          <= '0;
      warn_l          <= '0;
      reset_refused_o <= 1'b0;
    end
    else
    begin
      reset_refused_o <= fault_reset_i && ack_block; // RULE_15
      // Set beats clear; only sources whose fault has gone are released
      if (fault_reset_i && !ack_block)
      begin
        shutdown_out_l <= (shutdown_out_l & fault_i) | hit_shutdown_out; // RULE_04
        warn_l <= (warn_l & fault_i) | hit_warn; // RULE_06
      end
      else
      begin
        shutdown_out_l <= shutdown_out_l | hit_shutdown_out; // RULE_04 RULE_21
        warn_l <= warn_l | hit_warn; // RULE_06 RULE_21
      end
    end
  end

  // Messages follow the fault itself
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      msg_imp  <= '0;
      msg_free <= '0;
    end
    else
    begin
      msg_imp  <= hit_imp;  // RULE_07 RULE_21
      msg_free <= hit_free; // RULE_09 RULE_21
    end
  end

  // ******************************************************************
  // Reaction outputs
  // ******************************************************************
  always_comb
  begin
    field_inhibit_o     = |shutdown_out_l;                              // RULE_02
    armature_inhibit_o  = |shutdown_out_l || |msg_imp || |warn_l;       // RULE_02 RULE_07 RULE_18
    shutdown_out_o      = |shutdown_out_l;                              // RULE_02
    pulse_inhibit_out_o = |shutdown_out_l || |msg_imp || |warn_l;       // RULE_02 RULE_07 RULE_18
    ready_o             = ~|shutdown_out_l;                             // RULE_02
    warning_out_o       = |warn_l;                              // RULE_05
    message_out_o       = |msg_imp || |msg_free;                // RULE_07 RULE_09
  end

  // ******************************************************************
  // Indication codes and display
  // ******************************************************************
  logic [NS-1:0] show_shutdown_out;
  logic [NS-1:0] show_warn;
  logic [NS-1:0] show_imp;
  logic [NS-1:0] show_free;

  function automatic logic [7:0] first_code(input logic [NS-1:0] v);
    logic [7:0] c;
    c = `FRM_CODE_NONE;
    for (int i = NS - 1; i >= 0; i--)
      if (v[i])
        c = CODES[8*i +: 8];
    return c;
  endfunction

  always_comb
  begin
    for (int i = 0; i < NS; i++)
    begin
      // A latched shutdown_out is shown under the reaction now selected
      show_shutdown_out[i] = shutdown_out_l[i] && react[i] == FRM_R_SHUTDOWN_OUT; // RULE_19
      show_warn[i] = warn_l[i] || (shutdown_out_l[i] && react[i] == FRM_R_WARN);
      show_imp[i]  = msg_imp[i] || (shutdown_out_l[i] && react[i] == FRM_R_MSG_IMP);
      show_free[i] = msg_free[i] || (shutdown_out_l[i] && react[i] == FRM_R_MSG_FREE);
    end
    shutdown_indication_o = first_code(show_shutdown_out);             // RULE_03
    warning_indication_o  = first_code(show_warn);             // RULE_05
    message_indication_o  = first_code(show_imp | show_free);  // RULE_08
    if (|show_shutdown_out)
      display_class_o = FRM_D_SHUTDOWN_OUT;     // RULE_20
    else if (|show_warn)
      display_class_o = FRM_D_WARN;     // RULE_20
    else if (|show_imp)
      display_class_o = FRM_D_MSG_IMP;  // RULE_20
    else if (|show_free)
      display_class_o = FRM_D_MSG_FREE; // RULE_20
    else
      display_class_o = FRM_D_NONE;
    display_code_o = |show_shutdown_out ? shutdown_indication_o :
                     |show_warn ? warning_indication_o :
                     first_code(|show_imp ? show_imp : show_free); // RULE_20
  end

  // ******************************************************************
  // History buffers
  // ******************************************************************
  // Retained log keeps trips and warnings; mains-off never touches it.
  // The volatile log holds messages and is emptied when mains go off.
  // Simultaneous onsets queue as pending bits and drain one per cycle.
  logic [7:0]    ret_mem [HIST_DEPTH];
  logic [7:0]    vol_mem [HIST_DEPTH];
  logic [PW-1:0] ret_ptr;
  logic [PW-1:0] vol_ptr;
  logic [NS-1:0] ret_pend;
  logic [NS-1:0] vol_pend;
  logic [NS-1:0] ret_new;
  logic [NS-1:0] vol_new;
  logic [NS-1:0] ret_pick;
  logic [NS-1:0] vol_pick;

  always_comb
  begin
    ret_new  = (hit_shutdown_out & ~shutdown_out_l) | (hit_warn & ~warn_l);    // RULE_03 RULE_05
    vol_new  = (hit_imp & ~msg_imp) | (hit_free & ~msg_free);  // RULE_08
    ret_pick = ret_pend & (~ret_pend + 11'h001);
    vol_pick = vol_pend & (~vol_pend + 11'h001);
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ret_ptr  <= '0;
      ret_pend <= '0;
    end
    else
    begin
      ret_pend <= (ret_pend & ~ret_pick) | ret_new;
      if (|ret_pick)
      begin
        ret_mem[ret_ptr] <= first_code(ret_pick); // RULE_03 RULE_05
        ret_ptr          <= ret_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || mains_off_i)
    begin
      vol_ptr  <= '0;
      vol_pend <= '0;
      for (int i = 0; i < HIST_DEPTH; i++)
        vol_mem[i] <= `FRM_CODE_NONE; // RULE_08
    end
    else
    begin
      vol_pend <= (vol_pend & ~vol_pick) | vol_new;
      if (|vol_pick)
      begin
        vol_mem[vol_ptr] <= first_code(vol_pick); // RULE_08
        vol_ptr          <= vol_ptr + 1'b1;
      end
    end
  end

  // Index 0 is the newest entry
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      hist_code_o <= `FRM_CODE_NONE;
    else if (hist_sel_i)
      hist_code_o <= vol_mem[vol_ptr - hist_idx_i - 1'b1];
    else
      hist_code_o <= ret_mem[ret_ptr - hist_idx_i - 1'b1];
  end
endmodule

// >>> bench/frm_fault_checker_props.sv
// Port-level checks of the fault reaction manager
`timescale 1ns/1ps
module frm_fault_checker
(
  input logic                   clk_i,
  input logic                   reset_n_i,
  input logic [10:0]            fault_i,
  input logic                   cfg_we_i,
  input logic [3:0]             cfg_src_i,
  input frm_pkg::frm_reaction_t reaction_select_i,
  input logic                   fault_reset_i,
  input logic                   cfg_refused_o,
  input logic                   field_inhibit_o,
  input logic                   shutdown_out_o,
  input logic                   pulse_inhibit_out_o,
  input logic                   ready_o,
  input logic                   warning_out_o,
  input logic [7:0]             shutdown_indication_o,
  input logic [7:0]             warning_indication_o,
  input frm_pkg::frm_display_t  display_class_o,
  input logic [7:0]             display_code_o
);
  import frm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_SHUTDOWN_OUT_SET: assert property (fault_i[0] |=> shutdown_out_o && !ready_o)
    else $error("shutdown_out not raised");
  AST_READY: assert property (ready_o != shutdown_out_o)
    else $error("ready wrong");
  AST_FIELD: assert property (field_inhibit_o == shutdown_out_o)
    else $error("field inhibit wrong");
  AST_WARN_IMP: assert property (warning_out_o |-> pulse_inhibit_out_o)
    else $error("warning without inhibit");
  AST_SHUTDOWN_OUT_HOLD: assert property (shutdown_out_o && !fault_reset_i |=> shutdown_out_o)
    else $error("shutdown_out dropped");
  AST_DISP_SHUTDOWN_OUT: assert property (shutdown_indication_o != 8'h00 |->
    display_class_o == FRM_D_SHUTDOWN_OUT && display_code_o == shutdown_indication_o)
    else $error("shutdown_out not shown first");
  AST_DISP_WARN: assert property (shutdown_indication_o == 8'h00 &&
    warning_indication_o != 8'h00 |-> display_class_o == FRM_D_WARN)
    else $error("warning not shown");
  AST_CFG_BAD: assert property (cfg_we_i && (cfg_src_i > 4'ha ||
    cfg_src_i < 4'h3 && reaction_select_i != FRM_R_SHUTDOWN_OUT) |=> cfg_refused_o)
    else $error("bad setting taken");
endmodule

// >>> bench/frm_firing_model.sv
// Firing stage fed by the inhibit outputs
`timescale 1ns/1ps
module frm_firing_model
(
  input  logic armature_inhibit_i,
  input  logic field_inhibit_i,
  output logic armature_fire_o,
  output logic field_fire_o
);
  // Pulses only while not inhibited
  assign armature_fire_o = !armature_inhibit_i;
  assign field_fire_o    = !field_inhibit_i;
endmodule

// >>> bench/tb_top.sv
// Self-checking bench of the fault reaction manager
`timescale 1ns/1ps
module tb_top;
  import frm_pkg::*;
  logic          clk_i = 1'b0;
  logic          reset_n_i = 1'b0;
  logic [10:0]   fault_i = 11'h000;
  logic          cfg_we_i = 1'b0;
  logic [3:0]    cfg_src_i = 4'h0;
  frm_reaction_t reaction_select_i = FRM_R_SHUTDOWN_OUT;
  logic          fault_reset_i = 1'b0;
  logic          mains_off_i = 1'b0;
  logic          hist_sel_i = 1'b0;
  logic [2:0]    hist_idx_i = 3'h0;
  logic          cfg_refused_o, reset_refused_o, armature_inhibit_o, field_inhibit_o;
  logic          shutdown_out_o, pulse_inhibit_out_o, ready_o, warning_out_o, message_out_o;
  logic [7:0]    shutdown_indication_o, warning_indication_o, message_indication_o;
  logic [7:0]    display_code_o, hist_code_o;
  frm_display_t  display_class_o;
  logic          arm_fire, field_fire;
  int            num_errors = 0;
  int            comparisons = 0;
  int            cycles = 0;
  // Entry: source, refusal expected, reaction code
  logic [7:0]    cfg_tab [15] = '{8'h09, 8'h1c, 8'h2a, 8'h79, 8'h3a, 8'h5b, 8'h8c, 8'hb8,
                                  8'h4d, 8'h31, 8'h44, 8'h51, 8'h64, 8'h74, 8'h80};
  frm_fault_reaction_manager u_dut (.clk_i, .reset_n_i, .fault_i, .cfg_we_i, .cfg_src_i,
    .reaction_select_i, .fault_reset_i, .mains_off_i, .hist_sel_i, .hist_idx_i, .cfg_refused_o,
    .reset_refused_o, .armature_inhibit_o, .field_inhibit_o, .shutdown_out_o,
    .pulse_inhibit_out_o, .ready_o, .warning_out_o, .message_out_o, .shutdown_indication_o,
    .warning_indication_o, .message_indication_o, .display_class_o, .display_code_o,
    .hist_code_o);
  frm_firing_model u_fire (.armature_inhibit_i(armature_inhibit_o),
    .field_inhibit_i(field_inhibit_o), .armature_fire_o(arm_fire), .field_fire_o(field_fire));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic step();
    @(posedge clk_i) #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Leaves the write strobe high so back-to-back writes never toggle it in one step
  task automatic cfg(input logic [3:0] s, input logic [2:0] r, input logic refused);
    cfg_we_i = 1'b1;
    cfg_src_i = s;
    reaction_select_i = frm_reaction_t'(r);
    step();
    cmp({7'h00, cfg_refused_o}, {7'h00, refused}, "setting refusal");
  endtask
  task automatic ack(input logic [10:0] f, input logic refused);
    fault_i = f;
    fault_reset_i = 1'b1;
    step();
    cmp({7'h00, reset_refused_o}, {7'h00, refused}, "ack refusal");
    fault_reset_i = 1'b0;
    step();
  endtask
  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_shutdown_out();
    fault_i = 11'h109;
    step();
    cmp({4'h0, shutdown_out_o, ready_o, arm_fire, field_fire}, 8'h08, "shutdown_out outputs");
    cmp(shutdown_indication_o, 8'h47, "shutdown_out code");
    ack(11'h108, 1'b1);
    cmp(shutdown_indication_o, 8'h47, "blocked ack");
    ack(11'h008, 1'b0);
    cmp(shutdown_indication_o, 8'h3d, "default shutdown_out");
    ack(11'h000, 1'b0);
    cmp({7'h00, ready_o}, 8'h01, "shutdown_out cleared");
    cmp(hist_code_o, 8'h0f, "newest history");
    hist_idx_i = 3'h2;
    step();
    cmp(hist_code_o, 8'h47, "oldest history");
    hist_idx_i = 3'h0;
  endtask
  task automatic t_change();
    fault_i = 11'h010;
    step();
    fault_i = 11'h000;
    cfg(4'h4, 3'h1, 1'b0);
    cfg_we_i = 1'b0;
    cmp({7'h00, shutdown_out_o}, 8'h01, "shutdown_out kept");
    cmp({display_class_o, display_code_o[4:0]}, {FRM_D_WARN, 5'h10}, "new class");
    cmp(display_code_o, 8'h50, "new code");
    fault_i = 11'h020;
    step();
    cmp(display_code_o, 8'h51, "priority");
    cmp(warning_indication_o, 8'h50, "lower class kept");
    ack(11'h000, 1'b0);
    cmp({7'h00, shutdown_out_o}, 8'h00, "all cleared");
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 15; i++)
    begin
      // Protective sources 8 to 10 are never set to warning by this operator
      cfg(cfg_tab[i][7:4], cfg_tab[i][2:0], cfg_tab[i][3]);
    end
    cfg_we_i = 1'b0;
  endtask
  task automatic t_warn();
    fault_i = 11'h048;
    step();
    cmp(warning_indication_o, 8'h3d, "warning code");
    cmp({4'h0, warning_out_o, pulse_inhibit_out_o, field_fire, shutdown_out_o}, 8'h0e,
      "warn");
    cmp({7'h00, message_out_o}, 8'h00, "no message output");
    cmp(message_indication_o, 8'h00, "no message code");
    fault_i = 11'h000;
    step();
    cmp({7'h00, warning_out_o}, 8'h01, "warning latched");
    ack(11'h000, 1'b0);
    cmp({7'h00, warning_out_o}, 8'h00, "warning cleared");
    cmp(hist_code_o, 8'h3d, "warning history");
    hist_sel_i = 1'b1;
    mains_off_i = 1'b1;
    step();
    cmp(hist_code_o, 8'h00, "volatile history");
    hist_sel_i = 1'b0;
    mains_off_i = 1'b0;
    step();
    cmp(hist_code_o, 8'h3d, "retained after mains off");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    step();
    t_shutdown_out();
    t_change();
    t_cfg();
    t_warn();
    final_report();
  end
endmodule
bind frm_fault_reaction_manager frm_fault_checker u_chk (.clk_i, .reset_n_i, .fault_i,
  .cfg_we_i, .cfg_src_i, .reaction_select_i, .fault_reset_i, .cfg_refused_o, .field_inhibit_o,
  .shutdown_out_o, .pulse_inhibit_out_o, .ready_o, .warning_out_o, .shutdown_indication_o,
  .warning_indication_o, .display_class_o, .display_code_o);
